// [rtl/sfp_defines.vh]
// Constants shared by the serial flash pause and address-map front end
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH

// Array address map
`define SFP_ADDR_W 21
`define SFP_ARRAY_LAST 21'h1fffff
`define SFP_SEC_HI 20
`define SFP_SEC_LO 16
`define SFP_SUB_LO 12
`define SFP_PAGE_LO 8
`define SFP_OTP_HI 5

// Serial opcodes handled by the front end
`define SFP_OP_READ 8'h03
`define SFP_OP_PROG 8'h02
`define SFP_OP_SUB_ERASE 8'h20
`define SFP_OP_SEC_ERASE 8'hd8
`define SFP_OP_BULK_ERASE 8'hc7
`define SFP_OP_OTP_READ 8'h4b
`define SFP_OP_OTP_PROG 8'h42

// Erase granularity codes
`define SFP_ER_SUB 2'h0
`define SFP_ER_SEC 2'h1
`define SFP_ER_BULK 2'h2

// Framing counts
`define SFP_BIT_LAST 3'h7
`define SFP_ADDR_BYTE_LAST 2'h2

// Synchroniser reset image {sclk, cs_n, pause_n, data in}
`define SFP_SYNC_RST 4'h6

`endif

// [rtl/sfp_sync.v]
// Two-stage synchroniser for the serial link pins
`timescale 1ns/1ps

module sfp_sync #(
	parameter W = 4,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Asynchronous inputs and their synchronised copies
	input wire [W-1:0] d,
	output reg [W-1:0] sync_q
);

	reg [W-1:0] meta_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST;
			sync_q <= RST;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

endmodule

// [rtl/sfp_front.v]
// Serial flash front end: pause handling, framing and array address decode
`timescale 1ns/1ps
`include "sfp_defines.vh"

// Notes on behaviour
// - While paused, transfer stops but bit and byte position are kept.
// - Pause never touches a running internal write, program or erase cycle.
// - Pause can only be entered while chip select is low.
// - Pause starts on pause falling with clock low, else at next clock low.
// - Pause ends on pause rising with clock low, else at next clock low.
// - While paused, output floats and serial clock and input are ignored.
// - Chip select rising during pause resets the serial logic, dropping the transfer.
// - Array is 2 MiB, byte addresses 000000h to 1FFFFFh.
// - 512 subsectors of 4 KiB, index from address bits 20 to 12.
// - 32 sectors of 64 KiB, index from address bits 20 to 16.
// - 8192 pages of 256 bytes, index from address bits 20 to 8.
// - A separate 64-byte one-time area sits outside the array.
// - Programming stays within one page and only clears bits.
// - Erase sets bits, per subsector, sector or whole array, never per page.
module sfp_front (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Serial link pins
	input wire sclk,
	input wire cs_n,
	input wire pause_n,
	input wire serial_in_line,
	output wire serial_out_line,
	output wire serial_out_en,
	output wire paused,
	// Internal cycle status
	input wire cycle_busy,
	// Array and one-time area access
	output wire mem_rd_req,
	output wire mem_wr_req,
	output wire mem_otp_sel,
	output wire [20:0] mem_addr,
	output wire [12:0] page_index,
	output wire [7:0] mem_wr_data,
	input wire [7:0] mem_rd_data,
	// Erase requests
	output wire erase_req,
	output wire [1:0] erase_kind,
	output wire [4:0] erase_sector,
	output wire [8:0] erase_subsector
);

	localparam [2:0] ST_OP = 3'b000;
	localparam [2:0] ST_ADDR = 3'b001;
	localparam [2:0] ST_DUMMY = 3'b010;
	localparam [2:0] ST_DATA = 3'b011;
	localparam [2:0] ST_DONE = 3'b100;
	localparam [2:0] ST_IGNORE = 3'b101;

	////////////////////////////////////////////////////////////////////////////////
	// Address map helpers

	function [4:0] sector_of;
		input [20:0] a;
		begin
			sector_of = a[`SFP_SEC_HI:`SFP_SEC_LO];
		end
	endfunction

	function [8:0] subsector_of;
		input [20:0] a;
		begin
			subsector_of = a[`SFP_SEC_HI:`SFP_SUB_LO];
		end
	endfunction

	function [12:0] page_of;
		input [20:0] a;
		begin
			page_of = a[`SFP_SEC_HI:`SFP_PAGE_LO];
		end
	endfunction

	// Next address: one-time area wraps in 64 bytes, programming within its page
	function [20:0] adv;
		input [20:0] a;
		input otp;
		input prog;
		begin
			if (otp) begin
				adv = {15'h0, a[`SFP_OTP_HI:0] + 6'h1};
			end else if (prog) begin
				adv = {a[`SFP_SEC_HI:`SFP_PAGE_LO], a[`SFP_PAGE_LO-1:0] + 8'h1};
			end else if (a == `SFP_ARRAY_LAST) begin
				adv = 21'h0;
			end else begin
				adv = a + 21'h1;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and pause tracking

	wire [3:0] sync_w;
	wire sclk_s = sync_w[3];
	wire cs_n_s = sync_w[2];
	wire pause_n_s = sync_w[1];
	wire din_s = sync_w[0];

	sfp_sync #(
		.W(4),
		.RST(`SFP_SYNC_RST)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({sclk, cs_n, pause_n, serial_in_line}),
		.sync_q(sync_w)
	);

	reg sclk_q;
	reg cs_prev_q;
	reg paused_q;
	reg paused_d;

	always @* begin
		if (cs_n_s) begin
			paused_d = 1'b0;
		end else if (paused_q) begin
			paused_d = ~(pause_n_s & ~sclk_s);
		end else begin
			paused_d = ~pause_n_s & ~sclk_s;
		end
	end

	// Edges are invisible while paused
	wire rise = sclk_s & ~sclk_q & ~paused_q;
	wire fall = ~sclk_s & sclk_q & ~paused_q;

	////////////////////////////////////////////////////////////////////////////////
	// Framing state

	reg [2:0] st_q;
	reg [2:0] bit_q;
	reg [1:0] acnt_q;
	reg [7:0] shift_q;
	reg [7:0] op_q;
	reg [20:0] addr_q;
	reg [7:0] tx_q;
	reg drive_q;
	reg out_q;
	reg en_q;
	reg [7:0] rd_byte_q;
	reg [7:0] prog_byte_q;
	reg [1:0] pipe_q;
	reg [1:0] prog_pipe_q;
	reg rd_req_q;
	reg wr_req_q;
	reg otp_q;
	reg [20:0] mem_addr_q;
	reg [12:0] page_q;
	reg [7:0] wr_data_q;
	reg er_req_q;
	reg [1:0] er_kind_q;
	reg [4:0] er_sec_q;
	reg [8:0] er_sub_q;

	wire op_otp = (op_q == `SFP_OP_OTP_READ) | (op_q == `SFP_OP_OTP_PROG);
	wire op_prog = (op_q == `SFP_OP_PROG) | (op_q == `SFP_OP_OTP_PROG);
	wire byte_end = rise & (bit_q == `SFP_BIT_LAST);
	wire [7:0] byte_w = {shift_q[6:0], din_s};
	wire [20:0] full_addr = {addr_q[12:0], byte_w};

	reg iss_w;
	reg iss_prog_w;
	reg [20:0] iss_a_w;

	// Array access issue decision at each completed byte
	always @* begin
		iss_w = 1'b0;
		iss_prog_w = 1'b0;
		iss_a_w = addr_q;
		if (byte_end) begin
			if (st_q == ST_ADDR && acnt_q == `SFP_ADDR_BYTE_LAST && op_q == `SFP_OP_READ) begin
				iss_w = 1'b1;
				iss_a_w = full_addr;
			end else if (st_q == ST_DUMMY) begin
				iss_w = 1'b1;
			end else if (st_q == ST_DATA && !op_prog) begin
				iss_w = 1'b1;
				iss_a_w = adv(addr_q, op_otp, 1'b0);
			end else if (st_q == ST_DATA) begin
				iss_w = 1'b1;
				iss_prog_w = 1'b1;
			end
		end
	end

	wire iss_ok = iss_w & ~cycle_busy;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			cs_prev_q <= 1'b1;
			paused_q <= 1'b0;
			st_q <= ST_OP;
			bit_q <= 3'h0;
			acnt_q <= 2'h0;
			shift_q <= 8'h0;
			op_q <= 8'h0;
			addr_q <= 21'h0;
			tx_q <= 8'h0;
			drive_q <= 1'b0;
			out_q <= 1'b0;
			en_q <= 1'b0;
			rd_byte_q <= 8'h0;
			prog_byte_q <= 8'h0;
			pipe_q <= 2'h0;
			prog_pipe_q <= 2'h0;
			rd_req_q <= 1'b0;
			wr_req_q <= 1'b0;
			otp_q <= 1'b0;
			mem_addr_q <= 21'h0;
			page_q <= 13'h0;
			wr_data_q <= 8'h0;
			er_req_q <= 1'b0;
			er_kind_q <= `SFP_ER_SUB;
			er_sec_q <= 5'h0;
			er_sub_q <= 9'h0;
		end else begin
			sclk_q <= sclk_s;
			cs_prev_q <= cs_n_s;
			paused_q <= paused_d;
			en_q <= drive_q & ~paused_d & ~cs_n_s;
			rd_req_q <= iss_ok & ~iss_prog_w;
			pipe_q <= {pipe_q[0], iss_ok};
			prog_pipe_q <= {prog_pipe_q[0], iss_ok & iss_prog_w};
			wr_req_q <= 1'b0;
			er_req_q <= 1'b0;
			if (iss_ok) begin
				mem_addr_q <= iss_a_w;
				page_q <= page_of(iss_a_w);
				otp_q <= op_otp;
			end
			// Read data returns the cycle after the request
			if (pipe_q[1]) begin
				if (prog_pipe_q[1]) begin
					wr_req_q <= 1'b1;
					wr_data_q <= mem_rd_data & prog_byte_q;
				end else begin
					rd_byte_q <= mem_rd_data;
				end
			end
			if (cs_n_s) begin
				st_q <= ST_OP;
				bit_q <= 3'h0;
				acnt_q <= 2'h0;
				drive_q <= 1'b0;
				if (!cs_prev_q && st_q == ST_DONE && bit_q == 3'h0 && !cycle_busy && !paused_q) begin
					er_req_q <= 1'b1;
					er_sec_q <= sector_of(addr_q);
					er_sub_q <= subsector_of(addr_q);
					if (op_q == `SFP_OP_SUB_ERASE) begin
						er_kind_q <= `SFP_ER_SUB;
					end else if (op_q == `SFP_OP_SEC_ERASE) begin
						er_kind_q <= `SFP_ER_SEC;
					end else begin
						er_kind_q <= `SFP_ER_BULK;
					end
				end
			end else if (rise) begin
				shift_q <= byte_w;
				bit_q <= bit_q + 3'h1;
				if (bit_q == `SFP_BIT_LAST) begin
					case (st_q)
						ST_OP: begin
							op_q <= byte_w;
							acnt_q <= 2'h0;
							if (byte_w == `SFP_OP_READ || byte_w == `SFP_OP_PROG ||
								byte_w == `SFP_OP_SUB_ERASE || byte_w == `SFP_OP_SEC_ERASE ||
								byte_w == `SFP_OP_OTP_READ || byte_w == `SFP_OP_OTP_PROG) begin
								st_q <= ST_ADDR;
							end else if (byte_w == `SFP_OP_BULK_ERASE) begin
								st_q <= ST_DONE;
							end else begin
								st_q <= ST_IGNORE;
							end
						end
						ST_ADDR: begin
							addr_q <= full_addr;
							acnt_q <= acnt_q + 2'h1;
							if (acnt_q == `SFP_ADDR_BYTE_LAST) begin
								if (op_q == `SFP_OP_OTP_READ) begin
									st_q <= ST_DUMMY;
								end else if (op_q == `SFP_OP_SUB_ERASE || op_q == `SFP_OP_SEC_ERASE) begin
									st_q <= ST_DONE;
								end else begin
									st_q <= ST_DATA;
								end
							end
						end
						ST_DUMMY: begin
							st_q <= ST_DATA;
						end
						ST_DATA: begin
							if (op_prog) begin
								prog_byte_q <= byte_w;
								addr_q <= adv(addr_q, op_otp, 1'b1);
							end else begin
								addr_q <= iss_a_w;
							end
						end
						ST_DONE: begin
							st_q <= ST_IGNORE;
						end
						default: begin
							st_q <= st_q;
						end
					endcase
				end
			end else if (fall && st_q == ST_DATA && !op_prog) begin
				drive_q <= 1'b1;
				if (bit_q == 3'h0) begin
					out_q <= rd_byte_q[7];
					tx_q <= {rd_byte_q[6:0], 1'b0};
				end else begin
					out_q <= tx_q[7];
					tx_q <= {tx_q[6:0], 1'b0};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign serial_out_line = out_q;
	assign serial_out_en = en_q;
	assign paused = paused_q;
	assign mem_rd_req = rd_req_q;
	assign mem_wr_req = wr_req_q;
	assign mem_otp_sel = otp_q;
	assign mem_addr = mem_addr_q;
	assign page_index = page_q;
	assign mem_wr_data = wr_data_q;
	assign erase_req = er_req_q;
	assign erase_kind = er_kind_q;
	assign erase_sector = er_sec_q;
	assign erase_subsector = er_sub_q;

endmodule

// [dv/sfp_front_props.sv]
// Port checks for the serial flash front end
`timescale 1ns/1ps
module sfp_front_props (
	// Clock, reset and pins
	input wire clk,
	input wire rst_n,
	input wire cs_n,
	input wire pause_n,
	input wire paused,
	input wire serial_out_en,
	input wire cycle_busy,
	// Memory side
	input wire mem_rd_req,
	input wire mem_wr_req,
	input wire [20:0] mem_addr,
	input wire [12:0] page_index,
	input wire [7:0] mem_wr_data,
	input wire [7:0] mem_rd_data,
	input wire erase_req,
	input wire [1:0] erase_kind,
	input wire [4:0] erase_sector,
	input wire [8:0] erase_subsector
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_pause_floats: assert property (paused |-> !serial_out_en)
		else $error("output driven while paused");
	a_page_index: assert property ($stable(mem_addr) |-> page_index == mem_addr[20:8])
		else $error("page index off");
	a_erase_nesting: assert property (erase_req |-> erase_subsector[8:4] == erase_sector && erase_kind != 2'h3)
		else $error("erase indices off");
	a_pause_needs_select: assert property ($rose(paused) |-> !$past(cs_n, 2) && !$past(pause_n, 2))
		else $error("pause without select");
	a_deselect_clears: assert property (cs_n [*4] |=> !paused && !serial_out_en)
		else $error("deselect kept pause");
	a_wr_clears_only: assert property (mem_wr_req |-> (mem_wr_data & ~mem_rd_data) == 8'h00)
		else $error("program sets a bit");
	a_busy_no_access: assert property (cycle_busy [*6] |-> !mem_wr_req && !mem_rd_req && !erase_req)
		else $error("access during busy");
	a_abort_no_erase: assert property ($fell(paused) |-> !erase_req ##1 !erase_req)
		else $error("erase after abort");
	c_pause: cover property ($rose(paused));
	c_write: cover property (mem_wr_req);
	c_erase: cover property (erase_req);
endmodule
bind sfp_front sfp_front_props chk (
	.clk(clk),
	.rst_n(rst_n),
	.cs_n(cs_n),
	.pause_n(pause_n),
	.paused(paused),
	.serial_out_en(serial_out_en),
	.cycle_busy(cycle_busy),
	.mem_rd_req(mem_rd_req),
	.mem_wr_req(mem_wr_req),
	.mem_addr(mem_addr),
	.page_index(page_index),
	.mem_wr_data(mem_wr_data),
	.mem_rd_data(mem_rd_data),
	.erase_req(erase_req),
	.erase_kind(erase_kind),
	.erase_sector(erase_sector),
	.erase_subsector(erase_subsector)
);

// [dv/sfp_host.sv]
// Host controller model driving the serial link
`timescale 1ns/1ps
module sfp_host (
	// Link pins
	output logic sclk,
	output logic cs_n,
	output logic pause_n,
	output logic serial_in_line,
	input wire miso
);
	logic [7:0] rx;
	initial begin
		sclk = 0;
		cs_n = 1;
		pause_n = 1;
		serial_in_line = 1;
	end
	// One bit, data set while the clock is low
	task automatic clk_bit(input logic b);
		serial_in_line = b;
		#62.5 sclk = 1;
		rx = {rx[6:0], miso};
		#62.5 sclk = 0;
	endtask
	task automatic xb(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) clk_bit(d[i]);
	endtask
	task automatic sel();
		pause_n = 1;
		#41 cs_n = 0;
		#40;
	endtask
	// Clock stands low; released data line flips
	task automatic desel();
		#40 cs_n = 1;
		serial_in_line = ~serial_in_line;
		#200;
	endtask
endmodule

// [dv/tb.sv]
// Self-checking bench for the serial flash front end
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %h got %h", n, e, g); end end
module tb;
	logic clk = 0;
	logic rst_n = 0;
	logic cycle_busy = 0;
	int err_total = 0;
	int compares = 0;
	int wr_n = 0;
	int rd_n = 0;
	int er_n = 0;
	logic [7:0] wr_d;
	logic [1:0] er_k;
	logic [4:0] er_s;
	logic [8:0] er_u;
	wire sclk, cs_n, pause_n, serial_in_line, serial_out_line, serial_out_en, paused;
	wire mem_rd_req, mem_wr_req, mem_otp_sel, erase_req;
	wire [20:0] mem_addr;
	wire [12:0] page_index;
	wire [7:0] mem_wr_data;
	wire [1:0] erase_kind;
	wire [4:0] erase_sector;
	wire [8:0] erase_subsector;
	wire [7:0] mem_rd_data = mem_otp_sel ? {2'h3, mem_addr[5:0]} : mem_addr[7:0] ^ 8'h5a;
	// Released output shows the inverse so that a late enable is caught
	wire miso = serial_out_en ? serial_out_line : ~serial_out_line;
	sfp_front dut (
		.clk(clk),
		.rst_n(rst_n),
		.sclk(sclk),
		.cs_n(cs_n),
		.pause_n(pause_n),
		.serial_in_line(serial_in_line),
		.serial_out_line(serial_out_line),
		.serial_out_en(serial_out_en),
		.paused(paused),
		.cycle_busy(cycle_busy),
		.mem_rd_req(mem_rd_req),
		.mem_wr_req(mem_wr_req),
		.mem_otp_sel(mem_otp_sel),
		.mem_addr(mem_addr),
		.page_index(page_index),
		.mem_wr_data(mem_wr_data),
		.mem_rd_data(mem_rd_data),
		.erase_req(erase_req),
		.erase_kind(erase_kind),
		.erase_sector(erase_sector),
		.erase_subsector(erase_subsector)
	);
	sfp_host h (.sclk(sclk), .cs_n(cs_n), .pause_n(pause_n), .serial_in_line(serial_in_line), .miso(miso));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (mem_rd_req) begin
			rd_n <= rd_n + 1;
		end
		if (mem_wr_req) begin
			wr_n <= wr_n + 1;
			wr_d <= mem_wr_data;
		end
		if (erase_req) begin
			er_n <= er_n + 1;
			er_k <= erase_kind;
			er_s <= erase_sector;
			er_u <= erase_subsector;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic cmd(input logic [7:0] op, input logic [23:0] a);
		@(negedge clk);
		h.sel();
		h.xb(op);
		if (op != `SFP_OP_BULK_ERASE) begin
			h.xb(a[23:16]);
			h.xb(a[15:8]);
			h.xb(a[7:0]);
		end
	endtask
	task automatic t_read();
		cmd(`SFP_OP_READ, 24'hfffffe);
		h.xb(8'h00);
		`CHK("rd0", 8'ha4, h.rx)
		for (int i = 0; i < 3; i++) h.clk_bit(1'b0);
		h.pause_n = 0;
		#100 `CHK("paused", 1'b1, paused)
		`CHK("oe", 1'b0, serial_out_en)
		h.sclk = 1;
		#100 h.pause_n = 1;
		#100 `CHK("held", 1'b1, paused)
		h.sclk = 0;
		#100 `CHK("resumed", 1'b0, paused)
		`CHK("oe back", 1'b1, serial_out_en)
		for (int i = 0; i < 5; i++) h.clk_bit(1'b0);
		`CHK("rd1", 8'ha5, h.rx)
		h.xb(8'h00);
		`CHK("rd2", 8'h5a, h.rx)
		h.desel();
		`CHK("wrap", 21'h000001, mem_addr)
		`CHK("rd count", 4, rd_n)
	endtask
	task automatic t_otp();
		cmd(`SFP_OP_OTP_READ, 24'h00003f);
		h.xb(8'h00);
		h.xb(8'h00);
		`CHK("otp0", 8'hff, h.rx)
		h.xb(8'h00);
		`CHK("otp1", 8'hc0, h.rx)
		`CHK("otp sel", 1'b1, mem_otp_sel)
		h.desel();
		`CHK("otp rd count", 7, rd_n)
	endtask
	task automatic t_prog();
		cmd(`SFP_OP_PROG, 24'h0a12ff);
		h.xb(8'h0f);
		h.xb(8'hf0);
		h.desel();
		`CHK("wr count", 2, wr_n)
		`CHK("wr data", 8'h50, wr_d)
		`CHK("page", 13'h0a12, page_index)
		`CHK("wr addr", 21'h0a1200, mem_addr)
		`CHK("prog otp sel", 1'b0, mem_otp_sel)
		`CHK("prog rd count", 7, rd_n)
	endtask
	task automatic t_erase();
		logic [7:0] ops [3] = '{`SFP_OP_SUB_ERASE, `SFP_OP_SEC_ERASE, `SFP_OP_BULK_ERASE};
		for (int i = 0; i < 3; i++) begin
			cmd(ops[i], 24'h123456);
			h.desel();
			`CHK("erase", i + 1, er_n)
			`CHK("kind", 2'(i), er_k)
			`CHK("sector", 5'h12, er_s)
			if (i < 2) `CHK("subsector", 9'h123, er_u)
		end
	endtask
	task automatic t_abort();
		cmd(`SFP_OP_SUB_ERASE, 24'h123456);
		h.pause_n = 0;
		#100 h.cs_n = 1;
		#100 `CHK("abort", 1'b0, paused)
		`CHK("abort erase", 3, er_n)
		h.pause_n = 1;
		@(negedge clk) cycle_busy = 1;
		cmd(`SFP_OP_SEC_ERASE, 24'h123456);
		h.desel();
		`CHK("busy erase", 3, er_n)
		@(negedge clk) cycle_busy = 0;
		cmd(`SFP_OP_SEC_ERASE, 24'h1f0000);
		h.desel();
		`CHK("top sector", 5'h1f, er_s)
		`CHK("top sub", 9'h1f0, er_u)
	endtask
	task automatic stop_test();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1;
		repeat (4) @(negedge clk);
		t_read();
		t_otp();
		t_prog();
		t_erase();
		t_abort();
		stop_test();
	end
	initial begin
		#300000;
		err_total++;
		stop_test();
	end
endmodule
